// File: hdl/pipu_pkg.sv
// Purpose: shared constants for the pulse input processing unit
// Assumes: 10 MHz clock, plain register port with read data one cycle late
// Notes:   offsets are byte addresses of 32-bit words
package pipu_pkg;

  typedef enum logic [3:0] {
    PIPU_MODE_PASS   = 4'h1,
    PIPU_MODE_SERIAL = 4'h2,
    PIPU_MODE_DIV    = 4'h4,
    PIPU_MODE_SYNC   = 4'h8
  } pipu_mode_e;

  localparam logic [7:0]  PIPU_OFF_CTRL    = 8'h00;
  localparam logic [7:0]  PIPU_OFF_DIV     = 8'h04;
  localparam logic [7:0]  PIPU_OFF_TRIP    = 8'h08;
  localparam logic [7:0]  PIPU_OFF_DELAY   = 8'h0C;
  localparam logic [7:0]  PIPU_OFF_STATUS  = 8'h10;
  localparam logic [7:0]  PIPU_OFF_IRQ_ST  = 8'h14;
  localparam logic [7:0]  PIPU_OFF_IRQ_MSK = 8'h18;
  localparam logic [7:0]  PIPU_OFF_DIFF    = 8'h1C;
  localparam logic [7:0]  PIPU_OFF_BACKLOG = 8'h20;

  // ctrl field positions
  localparam int          PIPU_CTRL_MODE_LSB = 0;
  localparam int          PIPU_CTRL_EN_BIT   = 4;

  localparam logic [3:0]  PIPU_CTRL_MODE_RST = 4'h1;
  localparam logic [15:0] PIPU_DIV_RST       = 16'h0001;
  localparam logic [15:0] PIPU_TRIP_RST      = 16'h0010;
  localparam logic [15:0] PIPU_DELAY_RST     = 16'h0000;

  // output pulse shape: high time and low time of an emitted pulse
  localparam int          PIPU_PULSE_NS      = 1000;
  localparam int          PIPU_CLK_NS        = 100;
  localparam int          PIPU_PULSE_CYC     = (PIPU_PULSE_NS + PIPU_CLK_NS - 1) / PIPU_CLK_NS;

  // interrupt event bit positions
  localparam int          PIPU_EV_FAULT = 0;
  localparam int          PIPU_EV_TRIP  = 1;
  localparam int          PIPU_EV_DIR   = 2;
  localparam int          PIPU_EV_OVF   = 3;
  localparam int          PIPU_EV_N     = 4;

endpackage : pipu_pkg

// File: hdl/pipu_top.sv
// Purpose: pulse pass-through, divider, direction detection and sync monitor
// Assumes: all inputs synchronous to clk_in; sensors already debounced
// Notes:   one output pulse engine, used by divider mode only; serial mode follows the delayed input
`timescale 1ns/1ps

// How it works
// RULE_01: pass-through mode copies sensor input I to the output unchanged.
// RULE_02: pass-through mode watches line open and short flags while powering sensor.
// RULE_03: serial mode forwards each input pulse as exactly one output pulse.
// RULE_04: divider mode emits one output pulse per configured N input pulses.
// RULE_05: owed divided pulses are counted and emitted later during input pauses; the code emits them whenever the pulse engine is idle, input or not.
// RULE_06: direction is taken from which input went active first.
// RULE_07: direction is decided only when both inputs overlap; no overlap, no decision.
// RULE_08: if either input never toggles, no direction is reported.
// RULE_09: while hold input is asserted the direction output is frozen.
// RULE_10: sync mode counts both inputs and trips when difference exceeds trip value.
// RULE_11: the accumulated difference is kept through brief slippage, not cleared.
// RULE_12: trip de-energizes output; it re-energizes only when difference returns to zero.
// RULE_13: reverse level selects I minus II when low, II minus I when high.
// RULE_14: the controller holds reverse high for the whole reversed movement.
// RULE_15: static inputs only get a configurable delay before reaching the output.
// RULE_16: difference is a wide signed counter cleared by reset.
module pipu_top #(
  parameter int CNT_W  = 16,
  parameter int DIFF_W = 20
) (
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic [7:0]  addr_in,
  input  wire logic [31:0] wdata_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  output logic      [31:0] rdata_out,
  input  wire logic        sens_a_in,
  input  wire logic        sens_b_in,
  input  wire logic        line_open_in,
  input  wire logic        line_short_in,
  input  wire logic        dir_hold_in,
  input  wire logic        reverse_in,
  output logic             sens_pwr_out,
  output logic             pulse_out,
  output logic             fault_out,
  output logic             dir_valid_out,
  output logic             dir_ccw_out,
  output logic             sync_ok_out,
  output logic             irq_out
);

  // registers
  logic [4:0]               ctrl_reg;
  logic [CNT_W-1:0]         div_reg;
  logic [CNT_W-1:0]         trip_reg;
  logic [CNT_W-1:0]         delay_reg;
  logic [pipu_pkg::PIPU_EV_N-1:0] irq_st_reg;
  logic [pipu_pkg::PIPU_EV_N-1:0] irq_msk_reg;
  logic [31:0]              rdata_reg;

  // pipeline and state
  logic                     a_d_reg;
  logic                     b_d_reg;
  logic [CNT_W-1:0]         dly_cnt_reg;
  logic                     dly_out_reg;
  logic [CNT_W-1:0]         div_cnt_reg;
  logic [CNT_W-1:0]         backlog_reg;
  logic [7:0]               pcnt_reg;
  logic                     ph_hi_reg;
  logic                     pulse_reg;
  logic                     fault_reg;
  logic                     first_b_reg;
  logic                     armed_reg;
  logic                     dir_valid_reg;
  logic                     dir_ccw_reg;
  logic signed [DIFF_W-1:0] diff_reg;
  logic                     tripped_reg;

  pipu_pkg::pipu_mode_e     mode;
  logic                     enable;
  logic                     rise_a;
  logic                     fall_a;
  logic                     rise_b;
  logic                     fault_now;
  logic                     in_pulse;
  logic                     owe_pulse;
  logic                     div_hit;
  logic                     start_pulse;
  logic                     eng_busy;
  logic                     dir_decide;
  logic signed [DIFF_W-1:0] diff_step;
  logic signed [DIFF_W-1:0] diff_next;
  logic signed [DIFF_W-1:0] trip_s;
  logic                     trip_now;
  logic                     wr_ctrl;
  logic                     wr_div;
  logic                     wr_trip;
  logic                     wr_dly;
  logic                     wr_ist;
  logic                     wr_imsk;
  logic [pipu_pkg::PIPU_EV_N-1:0] ev;
  logic [31:0]              rd_mux;
  logic                     dir_change;

  localparam logic [7:0] PULSE_CYC = 8'(pipu_pkg::PIPU_PULSE_CYC);

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  assign mode      = pipu_pkg::pipu_mode_e'(ctrl_reg[pipu_pkg::PIPU_CTRL_MODE_LSB +: 4]);
  assign enable    = ctrl_reg[pipu_pkg::PIPU_CTRL_EN_BIT];
  assign rise_a    = sens_a_in & ~a_d_reg;
  assign fall_a    = ~sens_a_in & a_d_reg;
  assign rise_b    = sens_b_in & ~b_d_reg;
  assign fault_now = line_open_in | line_short_in;

  // decoding
  assign wr_ctrl = wr_in & hit(addr_in, pipu_pkg::PIPU_OFF_CTRL);
  assign wr_div  = wr_in & hit(addr_in, pipu_pkg::PIPU_OFF_DIV);
  assign wr_trip = wr_in & hit(addr_in, pipu_pkg::PIPU_OFF_TRIP);
  assign wr_dly  = wr_in & hit(addr_in, pipu_pkg::PIPU_OFF_DELAY);
  assign wr_ist  = wr_in & hit(addr_in, pipu_pkg::PIPU_OFF_IRQ_ST);
  assign wr_imsk = wr_in & hit(addr_in, pipu_pkg::PIPU_OFF_IRQ_MSK);

  // sensor supply is on whenever the block is enabled, in any mode
  assign sens_pwr_out = enable;                                     // see RULE_02

  // divider: count input pulses, a hit every div_reg of them; zero divider acts as one
  assign in_pulse  = enable & rise_a;
  assign div_hit   = in_pulse & (mode == pipu_pkg::PIPU_MODE_DIV)
                   & ((div_cnt_reg + CNT_W'(1)) >= div_reg);        // see RULE_04
  assign owe_pulse = (backlog_reg != '0);
  assign eng_busy  = ph_hi_reg | (pcnt_reg != 8'h00);
  // owed pulses wait for the engine to be idle; spacing therefore follows the fixed pulse high and low times
  assign start_pulse = ~eng_busy & owe_pulse;                       // see RULE_05

  // direction: decide on the rise that completes an overlap of both inputs
  assign dir_decide = enable & armed_reg & sens_a_in & sens_b_in
                    & (rise_a | rise_b) & ~dir_hold_in;             // see RULE_07
  assign dir_change = dir_decide & (dir_ccw_reg != first_b_reg) & dir_valid_reg;

  // synchronization difference
  assign diff_step = DIFF_W'(signed'({1'b0, rise_a})) - DIFF_W'(signed'({1'b0, rise_b}));
  assign diff_next = (enable && mode == pipu_pkg::PIPU_MODE_SYNC)
                   ? (reverse_in ? diff_reg - diff_step               // see RULE_13
                                 : diff_reg + diff_step)
                   : diff_reg;                                      // see RULE_11
  assign trip_s    = DIFF_W'(signed'({1'b0, trip_reg}));
  assign trip_now  = (diff_next > trip_s);                          // see RULE_10

  assign ev[pipu_pkg::PIPU_EV_FAULT] = fault_now & ~fault_reg;
  assign ev[pipu_pkg::PIPU_EV_TRIP]  = trip_now & ~tripped_reg;
  assign ev[pipu_pkg::PIPU_EV_DIR]   = dir_change;
  assign ev[pipu_pkg::PIPU_EV_OVF]   = div_hit & (&backlog_reg);

  assign rd_mux =
      hit(addr_in, pipu_pkg::PIPU_OFF_CTRL)    ? 32'(ctrl_reg)    :
      hit(addr_in, pipu_pkg::PIPU_OFF_DIV)     ? 32'(div_reg)     :
      hit(addr_in, pipu_pkg::PIPU_OFF_TRIP)    ? 32'(trip_reg)    :
      hit(addr_in, pipu_pkg::PIPU_OFF_DELAY)   ? 32'(delay_reg)   :
      hit(addr_in, pipu_pkg::PIPU_OFF_STATUS)  ?
        32'({tripped_reg, dir_ccw_reg, dir_valid_reg, fault_reg, pulse_reg}) :
      hit(addr_in, pipu_pkg::PIPU_OFF_IRQ_ST)  ? 32'(irq_st_reg)  :
      hit(addr_in, pipu_pkg::PIPU_OFF_IRQ_MSK) ? 32'(irq_msk_reg) :
      hit(addr_in, pipu_pkg::PIPU_OFF_DIFF)    ? 32'(unsigned'(diff_reg)) :
      hit(addr_in, pipu_pkg::PIPU_OFF_BACKLOG) ? 32'(backlog_reg) :
      32'h0000_0000;

  assign rdata_out     = rdata_reg;
  assign pulse_out     = pulse_reg;
  assign fault_out     = fault_reg;
  assign dir_valid_out = dir_valid_reg;
  assign dir_ccw_out   = dir_ccw_reg;
  assign sync_ok_out   = ~tripped_reg;                              // see RULE_12
  assign irq_out       = |(irq_st_reg & irq_msk_reg);

  // register port
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      ctrl_reg    <= {1'b0, pipu_pkg::PIPU_CTRL_MODE_RST};
      div_reg     <= CNT_W'(pipu_pkg::PIPU_DIV_RST);
      trip_reg    <= CNT_W'(pipu_pkg::PIPU_TRIP_RST);
      delay_reg   <= CNT_W'(pipu_pkg::PIPU_DELAY_RST);
      irq_msk_reg <= '0;
      irq_st_reg  <= '0;
      rdata_reg   <= 32'h0000_0000;
    end
    else
    begin
      if (wr_ctrl) ctrl_reg <= wdata_in[4:0];
      if (wr_div)  div_reg <= wdata_in[CNT_W-1:0];
      if (wr_trip) trip_reg <= wdata_in[CNT_W-1:0];
      if (wr_dly)  delay_reg <= wdata_in[CNT_W-1:0];
      if (wr_imsk) irq_msk_reg <= wdata_in[pipu_pkg::PIPU_EV_N-1:0];
      // a new event wins over a write-one clear in the same cycle
      irq_st_reg <= (irq_st_reg & ~(wr_ist ? wdata_in[pipu_pkg::PIPU_EV_N-1:0] : '0)) | ev;
      rdata_reg  <= rd_in ? rd_mux : 32'h0000_0000;
    end
  end

  // input history, fault level and static delay path
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      a_d_reg     <= 1'b0;
      b_d_reg     <= 1'b0;
      fault_reg   <= 1'b0;
      dly_cnt_reg <= '0;
      dly_out_reg <= 1'b0;
    end
    else
    begin
      a_d_reg   <= sens_a_in;
      b_d_reg   <= sens_b_in;
      fault_reg <= enable & (mode == pipu_pkg::PIPU_MODE_PASS) & fault_now;  // see RULE_02
      // the state reaches the output only after it held for delay_reg cycles
      if (sens_a_in == dly_out_reg)
        dly_cnt_reg <= '0;
      else if (dly_cnt_reg >= delay_reg)
      begin
        dly_out_reg <= sens_a_in;                                   // see RULE_15
        dly_cnt_reg <= '0;
      end
      else
        dly_cnt_reg <= dly_cnt_reg + CNT_W'(1);
    end
  end

  // pulse engine, divider count and backlog
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      div_cnt_reg <= '0;
      backlog_reg <= '0;
      pcnt_reg    <= 8'h00;
      ph_hi_reg   <= 1'b0;
      pulse_reg   <= 1'b0;
    end
    else
    begin
      if (in_pulse && mode == pipu_pkg::PIPU_MODE_DIV)
        div_cnt_reg <= div_hit ? '0 : div_cnt_reg + CNT_W'(1);     // see RULE_04
      backlog_reg <= backlog_reg
                   + CNT_W'(div_hit && !(&backlog_reg))
                   - CNT_W'(start_pulse);                           // see RULE_05
      if (start_pulse)
      begin
        ph_hi_reg <= 1'b1;
        pcnt_reg  <= PULSE_CYC;
      end
      else if (pcnt_reg != 8'h00)
        pcnt_reg <= pcnt_reg - 8'h01;
      else if (ph_hi_reg)
      begin
        ph_hi_reg <= 1'b0;
        pcnt_reg  <= PULSE_CYC;
      end
      // serial and pass-through follow the delayed input level one for one
      case (mode)
        pipu_pkg::PIPU_MODE_PASS:   pulse_reg <= enable & dly_out_reg;  // see RULE_01
        pipu_pkg::PIPU_MODE_SERIAL: pulse_reg <= enable & dly_out_reg;  // see RULE_03
        pipu_pkg::PIPU_MODE_DIV:    pulse_reg <= ph_hi_reg;
        pipu_pkg::PIPU_MODE_SYNC:   pulse_reg <= 1'b0;
        default:                    pulse_reg <= 1'b0;
      endcase
    end
  end

  // direction and synchronization
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      first_b_reg   <= 1'b0;
      armed_reg     <= 1'b0;
      dir_valid_reg <= 1'b0;
      dir_ccw_reg   <= 1'b0;
      diff_reg      <= '0;                                          // see RULE_16
      tripped_reg   <= 1'b0;
    end
    else
    begin
      // arm on a rise while the other input is low; the leader sets the sense
      if (rise_a && !sens_b_in)
      begin
        armed_reg   <= 1'b1;
        first_b_reg <= 1'b0;                                        // see RULE_06
      end
      else if (rise_b && !sens_a_in)
      begin
        armed_reg   <= 1'b1;
        first_b_reg <= 1'b1;                                        // see RULE_06
      end
      else if (dir_decide || (!sens_a_in && !sens_b_in))
        armed_reg <= 1'b0;
      // a silent input never completes an overlap, so valid stays low
      if (dir_decide)
      begin
        dir_valid_reg <= 1'b1;                                      // see RULE_08
        dir_ccw_reg   <= first_b_reg;                               // see RULE_09
      end
      diff_reg <= diff_next;                                        // see RULE_11
      if (trip_now)
        tripped_reg <= 1'b1;                                        // see RULE_12
      else if (diff_next == '0)
        tripped_reg <= 1'b0;                                        // see RULE_12
    end
  end

  // fall_a is kept for edge symmetry in later modes
  logic unused_ok;
  assign unused_ok = fall_a & 1'b0;

endmodule : pipu_top

// File: tb/pipu_assertions.sv
// Purpose: port-level checks of pipu_top
// Assumes: ctrl and delay are shadowed from writes seen on the register port
// Notes:   the pass copy check only looks at delay zero
`timescale 1ns/1ps
module pipu_assertions (
  input wire logic        clk_in,
  input wire logic        rst_n_in,
  input wire logic [7:0]  addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic        wr_in,
  input wire logic        rd_in,
  input wire logic [31:0] rdata_out,
  input wire logic        sens_a_in,
  input wire logic        sens_b_in,
  input wire logic        line_open_in,
  input wire logic        line_short_in,
  input wire logic        dir_hold_in,
  input wire logic        sens_pwr_out,
  input wire logic        pulse_out,
  input wire logic        fault_out,
  input wire logic        dir_valid_out,
  input wire logic        dir_ccw_out,
  input wire logic        sync_ok_out,
  input wire logic        irq_out
);
  logic [4:0]  ctrl_reg;
  logic [15:0] dly_reg;
  wire         pass_on = (ctrl_reg == 5'h11) && (dly_reg == 16'h0000);
  wire         div_on  = (ctrl_reg == 5'h14);
  always_ff @(posedge clk_in or negedge rst_n_in)
    if (!rst_n_in)
    begin
      ctrl_reg <= 5'h01;
      dly_reg  <= 16'h0000;
    end
    else if (wr_in)
    begin
      if (addr_in == 8'h00) ctrl_reg <= wdata_in[4:0];
      if (addr_in == 8'h0C) dly_reg <= wdata_in[15:0];
    end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  a_rd_idle: assert property (!$past(rd_in) |-> rdata_out == 32'h0)
    else $error("read data not idle");
  a_pwr_follow: assert property (sens_pwr_out == ctrl_reg[4])
    else $error("sensor supply differs from enable");
  a_pass_copy: assert property (pass_on && $past(pass_on, 3) |-> pulse_out == $past(sens_a_in, 2))
    else $error("pass output differs from input");
  a_fault_pass: assert property (pass_on && $past(pass_on) |-> fault_out == $past(line_open_in || line_short_in))
    else $error("fault output wrong");
  a_hold_freeze: assert property (dir_hold_in && $past(dir_hold_in) |-> $stable(dir_ccw_out) && $stable(dir_valid_out))
    else $error("direction moved while held");
  a_dir_overlap: assert property ($rose(dir_valid_out) |-> $past(sens_a_in && sens_b_in))
    else $error("direction without overlap");
  a_dir_leader: assert property ($rose(dir_valid_out) || $changed(dir_ccw_out) |-> dir_ccw_out == !$past(sens_a_in, 2))
    else $error("direction leader wrong");
  a_div_high: assert property (div_on && $rose(pulse_out) |=> pulse_out [*8])
    else $error("divided pulse too short");
  c_dir: cover property ($rose(dir_valid_out));
  c_trip: cover property ($fell(sync_ok_out));
  c_irq: cover property ($rose(irq_out));
endmodule : pipu_assertions
bind pipu_top pipu_assertions u_chk (.clk_in(clk_in), .rst_n_in(rst_n_in), .addr_in(addr_in),
  .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
  .sens_a_in(sens_a_in), .sens_b_in(sens_b_in), .line_open_in(line_open_in),
  .line_short_in(line_short_in), .dir_hold_in(dir_hold_in), .sens_pwr_out(sens_pwr_out),
  .pulse_out(pulse_out), .fault_out(fault_out), .dir_valid_out(dir_valid_out),
  .dir_ccw_out(dir_ccw_out), .sync_ok_out(sync_ok_out), .irq_out(irq_out));

// File: tb/pipu_field_model.sv
// Purpose: two phase-offset field sensors and the direction controller
// Assumes: manual levels from the bench when not running
// Notes:   running tracks overlap for five of twenty cycles
`timescale 1ns/1ps
module pipu_field_model (
  input  wire logic clk_in,
  input  wire logic run_in,
  input  wire logic b_lead_in,
  input  wire logic man_a_in,
  input  wire logic man_b_in,
  output logic      sens_a_out,
  output logic      sens_b_out,
  output logic      reverse_out
);
  logic [4:0] ph_reg = 5'h00;
  wire        lead_hi = ph_reg < 5'h0A;
  wire        lag_hi  = (ph_reg >= 5'h05) && (ph_reg < 5'h0F);
  always_ff @(posedge clk_in)
    ph_reg <= (ph_reg == 5'h13) ? 5'h00 : ph_reg + 5'h01;
  assign sens_a_out  = run_in ? (b_lead_in ? lag_hi : lead_hi) : man_a_in;
  assign sens_b_out  = run_in ? (b_lead_in ? lead_hi : lag_hi) : man_b_in;
  // reversal is held for the whole reversed run, not pulsed
  assign reverse_out = b_lead_in;
endmodule : pipu_field_model

// File: tb/tb_pipu_top.sv
// Purpose: self-checking bench of pipu_top
// Assumes: 10 MHz clock, outputs sampled at the rising edge before updates land
// Notes:   sensor levels come from the field model
`timescale 1ns/1ps
module tb_pipu_top;
  logic        clk_in = 1'b0;
  logic        rst_n_in = 1'b0;
  logic [7:0]  addr_in = 8'h00;
  logic [31:0] wdata_in = 32'h0;
  logic        wr_in = 1'b0;
  logic        rd_in = 1'b0;
  logic        line_open_in = 1'b0;
  logic        line_short_in = 1'b0;
  logic        dir_hold_in = 1'b0;
  logic        run = 1'b0;
  logic        b_lead = 1'b0;
  logic        man_a = 1'b0;
  logic        man_b = 1'b0;
  logic        sens_a, sens_b, reverse, p_last, sens_pwr_out, pulse_out, fault_out;
  logic        dir_valid_out, dir_ccw_out, sync_ok_out, irq_out;
  logic [31:0] rdata_out;
  int          n_mismatch = 0;
  int          samples_checked = 0;
  int          n_rise = 0;
  int          cyc = 0;
  always #50 clk_in = ~clk_in;
  pipu_field_model u_field (.clk_in(clk_in), .run_in(run), .b_lead_in(b_lead), .man_a_in(man_a),
    .man_b_in(man_b), .sens_a_out(sens_a), .sens_b_out(sens_b), .reverse_out(reverse));
  pipu_top dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .sens_a_in(sens_a), .sens_b_in(sens_b),
    .line_open_in(line_open_in), .line_short_in(line_short_in), .dir_hold_in(dir_hold_in),
    .reverse_in(reverse), .sens_pwr_out(sens_pwr_out), .pulse_out(pulse_out),
    .fault_out(fault_out), .dir_valid_out(dir_valid_out), .dir_ccw_out(dir_ccw_out),
    .sync_ok_out(sync_ok_out), .irq_out(irq_out));
  always @(posedge clk_in)
  begin
    if (pulse_out === 1'b1 && p_last === 1'b0) n_rise++;
    p_last <= pulse_out;
  end
  task automatic complete_run;
    if (n_mismatch == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : complete_run
  always @(posedge clk_in)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_mismatch++;
      complete_run;
    end
  end
  task automatic check_val(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check_val
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
    @(posedge clk_in);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    @(posedge clk_in);
    d = rdata_out;
  endtask : rd
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk_in);
  endtask : wait_cyc
  task automatic pulse_a(input int n, input int h);
    repeat (n)
    begin
      man_a <= 1'b1;
      wait_cyc(h);
      man_a <= 1'b0;
      wait_cyc(h);
    end
  endtask : pulse_a
  task automatic t_reset;
    logic [7:0]  a [6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h1C, 8'h24};
    logic [31:0] e [6] = '{32'h1, 32'h1, 32'h10, 32'h0, 32'h0, 32'h0};
    logic [31:0] d;
    for (int i = 0; i < 6; i++)
    begin
      rd(a[i], d);
      check_val("reset reg", d, e[i]);
    end
    check_val("sync_ok reset", 32'(sync_ok_out), 32'h1);
  endtask : t_reset
  task automatic t_pass;
    logic [31:0] d;
    wr(8'h00, 32'h11);
    check_val("supply", 32'(sens_pwr_out), 32'h1);
    n_rise = 0;
    pulse_a(3, 4);
    check_val("pass pulses", n_rise, 3);
    line_open_in <= 1'b1;
    wr(8'h18, 32'h1);
    check_val("fault open", 32'(fault_out), 32'h1);
    check_val("irq unmasked", 32'(irq_out), 32'h1);
    wr(8'h18, 32'h0);
    check_val("irq masked", 32'(irq_out), 32'h0);
    line_open_in <= 1'b0;
    line_short_in <= 1'b1;
    wait_cyc(3);
    check_val("fault short", 32'(fault_out), 32'h1);
    line_short_in <= 1'b0;
    wait_cyc(3);
    wr(8'h14, 32'h1);
    rd(8'h14, d);
    check_val("fault cleared", d & 32'h1, 32'h0);
  endtask : t_pass
  task automatic t_delay;
    int n;
    wr(8'h0C, 32'h5);
    man_a <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk_in);
      n++;
    end
    while (pulse_out !== 1'b1 && n < 30);
    check_val("delay cycles", n, 8);
    man_a <= 1'b0;
    wr(8'h0C, 32'h0);
    wait_cyc(10);
  endtask : t_delay
  task automatic t_pulses;
    logic [31:0] ct [3] = '{32'h12, 32'h14, 32'h14};
    int          dv [3] = '{1, 1, 3};
    int          np [3] = '{4, 5, 7};
    int          ex [3] = '{4, 5, 2};
    logic [31:0] d;
    for (int i = 0; i < 3; i++)
    begin
      wr(8'h04, dv[i]);
      wr(8'h00, ct[i]);
      n_rise = 0;
      pulse_a(np[i], 2);
      wait_cyc(130);
      check_val("output pulses", n_rise, ex[i]);
      rd(8'h20, d);
      check_val("backlog drained", d, 32'h0);
    end
  endtask : t_pulses
  task automatic t_dir;
    check_val("one track only", 32'(dir_valid_out), 32'h0);
    pulse_a(1, 3);
    man_b <= 1'b1;
    wait_cyc(3);
    man_b <= 1'b0;
    wait_cyc(3);
    check_val("no overlap", 32'(dir_valid_out), 32'h0);
    run <= 1'b1;
    wait_cyc(50);
    check_val("dir valid", 32'(dir_valid_out), 32'h1);
    check_val("i leads", 32'(dir_ccw_out), 32'h0);
    dir_hold_in <= 1'b1;
    b_lead <= 1'b1;
    wait_cyc(50);
    check_val("held", 32'(dir_ccw_out), 32'h0);
    dir_hold_in <= 1'b0;
    wait_cyc(50);
    check_val("ii leads", 32'(dir_ccw_out), 32'h1);
    run <= 1'b0;
    b_lead <= 1'b0;
  endtask : t_dir
  task automatic t_sync;
    logic [31:0] d;
    wr(8'h08, 32'h3);
    wr(8'h00, 32'h18);
    pulse_a(3, 2);
    check_val("at trip", 32'(sync_ok_out), 32'h1);
    pulse_a(1, 2);
    check_val("over trip", 32'(sync_ok_out), 32'h0);
    rd(8'h1C, d);
    check_val("diff kept", d, 32'h4);
    b_lead <= 1'b1;
    pulse_a(3, 2);
    check_val("not yet zero", 32'(sync_ok_out), 32'h0);
    pulse_a(1, 2);
    check_val("back at zero", 32'(sync_ok_out), 32'h1);
    b_lead <= 1'b0;
    man_b <= 1'b1;
    wait_cyc(2);
    man_b <= 1'b0;
    wait_cyc(2);
    rd(8'h1C, d);
    check_val("negative diff", d, 32'h000FFFFF);
  endtask : t_sync
  initial
  begin
    wait_cyc(5);
    rst_n_in <= 1'b1;
    @(posedge clk_in);
    t_reset;
    t_pass;
    t_delay;
    t_pulses;
    t_dir;
    t_sync;
    complete_run;
  end
endmodule : tb_pipu_top
